// [dv/abr_fifo_sink.sv]
`timescale 1ns/1ps
// Host-side model that drains the receive FIFO stream.
// In slow mode it drops ready every other cycle, as a busy host would.
module abr_fifo_sink (
  // Clock and mode
  input logic clk_sys,
  input logic ce,
  input logic slow,
  // Quadlet stream
  input logic q_valid,
  output logic q_ready,
  input logic [31:0] q_data,
  input logic q_bulky,
  input logic q_first,
  input logic q_last,
  // Observations
  output int frag_errs
);
  logic [34:0] got[$];
  logic in_pkt;

  initial begin
    q_ready = 1'b1;
    frag_errs = 0;
    in_pkt = 1'b0;
  end

  always @(negedge clk_sys) begin
    q_ready <= slow ? ~q_ready : 1'b1;
  end

  // A start word arriving inside an open packet means two packets were mixed.
  always @(posedge clk_sys) begin
    if (q_valid && q_ready && ce) begin
      got.push_back({q_bulky, q_first, q_last, q_data});
      if (q_first && in_pkt) frag_errs <= frag_errs + 1;
      in_pkt <= q_last ? 1'b0 : (q_first ? 1'b1 : in_pkt);
    end
  end
endmodule : abr_fifo_sink

// [dv/test_abr_rx_formatter.sv]
`timescale 1ns/1ps
module test_abr_rx_formatter;
  import abr_pkg::*;
  logic clk_sys = 0, arst_n = 0, ce = 1, slow = 0;
  logic hdr_valid = 0, hdr_ready, hdr_bulky = 0;
  logic [BUS_W-1:0] dst_bus = 10'h2a5;
  logic [NODE_W-1:0] dst_node = 6'h3e;
  logic [TLABEL_W-1:0] tlabel = '0;
  logic [RETRY_W-1:0] retry = '0;
  logic [TCODE_W-1:0] tcode = '0;
  logic [PRIO_W-1:0] priority_in = '0;
  logic [ID_W-1:0] src_id = 16'hc1d3;
  logic [OFF_HI_W-1:0] offset_high = '0;
  logic [OFF_LO_W-1:0] offset_low = '0;
  logic [LEN_W-1:0] data_length = '0;
  logic [EXT_W-1:0] ext_tcode = '0;
  logic [SPD_W-1:0] spd = '0;
  logic [ACK_W-1:0] ack_sent = '0;
  logic byte_valid = 0, byte_last = 0, byte_ready;
  logic [7:0] byte_data = '0;
  logic q_valid, q_ready, q_bulky, q_first, q_last;
  logic [QUAD_W-1:0] q_data;
  int miscompares = 0, checks_done = 0, cyc = 0, frag_errs;
  logic [31:0] exp_q[$];

  abr_rx_formatter dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .hdr_bulky(hdr_bulky), .dst_bus(dst_bus), .dst_node(dst_node), .tlabel(tlabel),
    .retry(retry), .tcode(tcode), .priority_in(priority_in), .src_id(src_id), .offset_high(offset_high),
    .offset_low(offset_low), .data_length(data_length), .ext_tcode(ext_tcode), .spd(spd),
    .ack_sent(ack_sent), .byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last),
    .byte_ready(byte_ready), .q_valid(q_valid), .q_ready(q_ready), .q_data(q_data), .q_bulky(q_bulky),
    .q_first(q_first), .q_last(q_last));

  abr_fifo_sink part_u (.clk_sys(clk_sys), .ce(ce), .slow(slow), .q_valid(q_valid), .q_ready(q_ready),
    .q_data(q_data), .q_bulky(q_bulky), .q_first(q_first), .q_last(q_last), .frag_errs(frag_errs));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // A hang anywhere ends the run through the normal report.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Expectations are built before the header is offered; the bus, source ID, label and extended
  // tcode inputs are scrambled after the take to show they are sampled only on that edge.
  task automatic run_pkt(input logic bk, input logic [3:0] tc, input logic [15:0] len, input logic [1:0] rt,
                         input logic [1:0] sp, input logic [15:0] oh, input logic [31:0] ol, input logic hold);
    int nq;
    int n;
    logic [31:0] tr;
    logic [31:0] w;
    nq = (tc == 4'h1 || tc == 4'h7 || tc == 4'h9 || tc == 4'hb) ? (len + 3) / 4 : 0;
    tr = {14'h0, sp, 2'h0, (nq > 0) ? 2'((4 - len % 4) % 4) : 2'h0, 8'h0, ~tc};
    exp_q.delete();
    if (bk) exp_q.push_back(tr);
    exp_q.push_back({10'h2a5, 6'h3e, 6'(tc) + 6'h11, rt, tc, 4'h0});
    exp_q.push_back({16'hc1d3, (tc == 4'hb) ? {oh[15:12], 12'h000} : oh});
    exp_q.push_back({ol[31:2], 2'h0});
    exp_q.push_back({len, tc, 12'h123});
    for (int q = 0; q < nq; q++) begin
      for (int b = 0; b < 4; b++) w[31 - 8 * b -: 8] = (4 * q + b < len) ? 8'ha0 + 8'(4 * q + b) : 8'h00;
      exp_q.push_back(w);
    end
    if (!bk) exp_q.push_back(tr);
    @(negedge clk_sys);
    {hdr_bulky, tcode, data_length, retry, spd, offset_high, offset_low} = {bk, tc, len, rt, sp, oh, ol};
    {dst_bus, dst_node, src_id, priority_in} = {10'h2a5, 6'h3e, 16'hc1d3, 4'h5};
    {tlabel, ext_tcode, ack_sent} = {6'(tc) + 6'h11, tc, 12'h123, ~tc};
    hdr_valid = 1'b1;
    // Ready is read between edges, where it has settled; the take happens at the next rising edge.
    while (!(hdr_ready && ce)) @(negedge clk_sys);
    @(negedge clk_sys);
    hdr_valid = 1'b0;
    {dst_bus, src_id, tlabel, ext_tcode} = ~{dst_bus, src_id, tlabel, ext_tcode};
    for (int i = 0; i < len && nq > 0; i++) begin
      {byte_valid, byte_data, byte_last} = {1'b1, 8'ha0 + 8'(i), i == len - 1};
      if (hold && i == 1) begin
        ce = 1'b0;
        repeat (3) @(negedge clk_sys);
        ce = 1'b1;
      end
      while (!(byte_ready && ce)) @(negedge clk_sys);
      @(negedge clk_sys);
    end
    byte_valid = 1'b0;
    n = 0;
    while (part_u.got.size() < exp_q.size() && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    chk("word count", 35'(exp_q.size()), 35'(part_u.got.size()));
    foreach (exp_q[i]) chk("quadlet", {bk, i == 0, i == exp_q.size() - 1, exp_q[i]}, part_u.got[i]);
    chk("interleave", 35'h0, 35'(frag_errs));
    part_u.got.delete();
  endtask : run_pkt

  task automatic t_write_ctrl();
    run_pkt(1'b0, TC_WRITE_REQ_BLK, 16'h0005, RETRY_NEW, SPD_100, 16'hffff, 32'h1234_5677, 1'b0);
  endtask : t_write_ctrl

  task automatic t_read_req_bulky();
    run_pkt(1'b1, TC_READ_REQ_BLK, 16'h0008, RETRY_X, SPD_200, 16'h0001, 32'h0000_0008, 1'b0);
  endtask : t_read_req_bulky

  task automatic t_read_resp_stall();
    slow = 1'b1;
    run_pkt(1'b1, TC_READ_RESP_BLK, 16'h0004, RETRY_A, SPD_400, 16'h8000, 32'hffff_fffe, 1'b1);
    slow = 1'b0;
  endtask : t_read_resp_stall

  task automatic t_lock_resp();
    run_pkt(1'b0, TC_LOCK_RESP, 16'h0007, RETRY_B, SPD_UNDEF, 16'habcd, 32'h0000_0101, 1'b0);
  endtask : t_lock_resp

  task automatic t_write_resp();
    run_pkt(1'b0, TC_WRITE_RESP, 16'h0000, RETRY_NEW, SPD_200, 16'h00f0, 32'h0000_0010, 1'b0);
  endtask : t_write_resp

  task automatic t_lock_req_bulky();
    slow = 1'b1;
    run_pkt(1'b1, TC_LOCK_REQ, 16'h0001, RETRY_X, SPD_100, 16'h0f0f, 32'h0000_0203, 1'b0);
    slow = 1'b0;
  endtask : t_lock_req_bulky

  initial begin
    repeat (10) @(negedge clk_sys);
    chk("hdr_ready in reset", 35'h1, 35'(hdr_ready));
    chk("q_valid in reset", 35'h0, 35'(q_valid));
    chk("byte_ready in reset", 35'h1, 35'(byte_ready));
    chk("q flags in reset", 35'h0, {q_bulky, q_first, q_last, q_data});
    arst_n = 1'b1;
    // The design shows hdr_ready high while still held in reset, so wait out the synchroniser.
    repeat (3) @(negedge clk_sys);
    t_write_ctrl();
    t_read_req_bulky();
    t_read_resp_stall();
    t_lock_resp();
    t_write_resp();
    t_lock_req_bulky();
    summarize();
  end
endmodule : test_abr_rx_formatter

// [hw/abr_byte_packer.sv]
`timescale 1ns/1ps
module abr_byte_packer (
  // Clock and control
  input logic clk_sys,
  input logic rst_n,
  input logic ce,
  // Byte side
  input logic byte_valid,
  input logic [7:0] byte_data,
  input logic byte_last,
  output logic byte_ready,
  // Quadlet side
  output logic quad_valid,
  output logic [abr_pkg::QUAD_W-1:0] quad_data,
  input logic quad_take
);
  import abr_pkg::*;

  logic [QUAD_W-1:0] acc_reg;
  logic [ZFC_W-1:0] fill_reg;
  logic full_reg;
  logic ready_reg;

  wire accept = ce && byte_valid && ready_reg;
  wire close = accept && ((fill_reg == 2'h3) || byte_last);
  // Byte 0 goes to the top lane whatever the target address alignment.
  wire [QUAD_W-1:0] acc_ins = acc_reg | ({byte_data, 24'h00_0000} >> {fill_reg, 3'h0}); // [R15]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      fill_reg <= '0;
      full_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else if (ce) begin
      if (quad_take) begin
        // Clearing here leaves unused lanes of a short last quadlet at zero.
        acc_reg <= '0; // [R16]
        full_reg <= 1'b0;
        ready_reg <= 1'b1;
      end else if (accept) begin
        acc_reg <= acc_ins;
        fill_reg <= close ? 2'h0 : fill_reg + 2'h1;
        full_reg <= close;
        ready_reg <= !close;
      end
    end
  end

  assign byte_ready = ready_reg;
  assign quad_valid = full_reg;
  assign quad_data = acc_reg;

  a_first_lane: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R15]
    accept && (fill_reg == 2'h0) |=> acc_reg[31:24] == $past(byte_data))
    else $error("first byte not in top lane");

  a_pad_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R16]
    accept && byte_last && (fill_reg == 2'h0) |=> acc_reg[23:0] == 24'h00_0000)
    else $error("short quadlet not zero padded");

endmodule : abr_byte_packer

// [hw/abr_rx_formatter.sv]
`timescale 1ns/1ps
// Summary of operation
// [R01] Word 0: destination ID high, control low.
// [R02] Word 1 source ID; offset spans words 1-2.
// [R03] Data quadlets only when tcode carries data.
// [R04] Trailer last for control, first for bulky.
// [R05] Destination ID is bus then node number.
// [R06] Transaction label passes through unchanged.
// [R07] Retry code passes through with standard encoding.
// [R08] Transaction code sits in word 0 low.
// [R09] Cable use forces priority bits to zero.
// [R10] Source ID holds the sender's node ID.
// [R11] Destination offset is quadlet aligned.
// [R12] Lock response: rcode on top, rest zero.
// [R13] Length counts payload bytes, not header.
// [R14] Extended tcode travels beside the length.
// [R15] First payload byte lands in byte 0.
// [R16] Unused bytes of last quadlet are zero.
// [R17] Trailer reports received speed code.
// [R18] Trailer reports the acknowledge sent.
// [R19] Trailer reports zero-filled byte count.
// [R20] Packet quadlets are contiguous, never interleaved.
module abr_rx_formatter #(
  parameter bit CABLE_MODE = 1'b1
) (
  // Clock, reset and enable
  input logic clk_sys,
  input logic arst_n,
  input logic ce,
  // Header from the link receiver
  input logic hdr_valid,
  output logic hdr_ready,
  input logic hdr_bulky,
  input logic [abr_pkg::BUS_W-1:0] dst_bus,
  input logic [abr_pkg::NODE_W-1:0] dst_node,
  input logic [abr_pkg::TLABEL_W-1:0] tlabel,
  input logic [abr_pkg::RETRY_W-1:0] retry,
  input logic [abr_pkg::TCODE_W-1:0] tcode,
  input logic [abr_pkg::PRIO_W-1:0] priority_in,
  input logic [abr_pkg::ID_W-1:0] src_id,
  input logic [abr_pkg::OFF_HI_W-1:0] offset_high,
  input logic [abr_pkg::OFF_LO_W-1:0] offset_low,
  input logic [abr_pkg::LEN_W-1:0] data_length,
  input logic [abr_pkg::EXT_W-1:0] ext_tcode,
  input logic [abr_pkg::SPD_W-1:0] spd,
  input logic [abr_pkg::ACK_W-1:0] ack_sent,
  // Payload bytes from the link receiver
  input logic byte_valid,
  input logic [7:0] byte_data,
  input logic byte_last,
  output logic byte_ready,
  // Quadlet stream to the receive FIFOs
  output logic q_valid,
  input logic q_ready,
  output logic [abr_pkg::QUAD_W-1:0] q_data,
  output logic q_bulky,
  output logic q_first,
  output logic q_last
);
  import abr_pkg::*;

  // Reset release is synchronised; assertion stays asynchronous.
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_n_reg;

  // Header word composition.
  wire [PRIO_W-1:0] prio_eff = CABLE_MODE ? PRIO_CABLE : priority_in; // [R09]
  wire [ID_W-1:0] dst_id = {dst_bus, dst_node}; // [R05]
  wire is_lock_resp = (tcode == TC_LOCK_RESP);
  wire [OFF_HI_W-1:0] off_hi_eff = is_lock_resp ?
    {offset_high[OFF_HI_W-1 -: RCODE_W], RCODE_RSVD_ZERO} : offset_high; // [R12]
  wire [QUAD_W-1:0] word0 = {dst_id, tlabel, retry, tcode, prio_eff}; // [R01] [R06] [R07] [R08]
  wire [QUAD_W-1:0] word1 = {src_id, off_hi_eff}; // [R02] [R10]
  wire [QUAD_W-1:0] word2 = offset_low & QUAD_ALIGN_MASK; // [R02] [R11]
  wire [QUAD_W-1:0] word3 = {data_length, ext_tcode}; // [R13] [R14]

  wire [QUAD_W-1:0] trl_word;
  wire [QCNT_W-1:0] quad_count;

  abr_trailer_build u_trailer (
    .data_length(data_length),
    .tcode(tcode),
    .spd(spd),
    .ack_sent(ack_sent),
    .trailer(trl_word),
    .quad_count(quad_count)
  );

  // Packet state.
  abr_state_t state_reg;
  abr_state_t state_next;
  logic [QUAD_W-1:0] hdr_mem [0:HDR_WORDS-1];
  logic [QUAD_W-1:0] trl_reg;
  logic [QCNT_W-1:0] quads_left_reg;
  logic [HIDX_W-1:0] hidx_reg;
  logic bulky_reg;
  logic hdr_ready_reg;

  // Output stage.
  logic q_valid_reg;
  logic [QUAD_W-1:0] q_data_reg;
  logic q_bulky_reg;
  logic q_first_reg;
  logic q_last_reg;

  wire pk_valid;
  wire [QUAD_W-1:0] pk_data;

  // One quadlet may move into the output stage when it is empty or drained.
  wire advance = ce && (!q_valid_reg || q_ready);
  wire hdr_take = ce && hdr_valid && hdr_ready_reg;
  wire in_data = (state_reg == ST_DATA);
  wire pk_take = advance && in_data && pk_valid;
  wire hdr_end = (hidx_reg == HDR_IDX_LAST);
  wire no_data = (quads_left_reg == '0);
  wire final_data = (quads_left_reg == QCNT_W'(1));
  wire [QUAD_W-1:0] hdr_word = hdr_mem[hidx_reg];

  // Selection of the quadlet presented next.
  logic emit;
  logic [QUAD_W-1:0] emit_word;
  logic emit_first;
  logic emit_last;

  // One packet is sent start to end before another header is taken.
  always_comb begin
    state_next = state_reg;
    emit = 1'b0;
    emit_word = '0;
    emit_first = 1'b0;
    emit_last = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (hdr_take) begin
          state_next = hdr_bulky ? ST_TRL_FIRST : ST_HDR; // [R20]
        end
      end
      ST_TRL_FIRST: begin
        emit = 1'b1;
        emit_word = trl_reg; // [R04]
        emit_first = 1'b1;
        if (advance) begin
          state_next = ST_HDR;
        end
      end
      ST_HDR: begin
        emit = 1'b1;
        emit_word = hdr_word;
        emit_first = !bulky_reg && (hidx_reg == HDR_IDX_FIRST);
        emit_last = bulky_reg && hdr_end && no_data;
        if (advance && hdr_end) begin
          if (!no_data) begin
            state_next = ST_DATA; // [R03]
          end else begin
            state_next = bulky_reg ? ST_IDLE : ST_TRL_LAST;
          end
        end
      end
      ST_DATA: begin
        emit = pk_valid;
        emit_word = pk_data;
        emit_last = bulky_reg && final_data;
        if (pk_take && final_data) begin
          state_next = bulky_reg ? ST_IDLE : ST_TRL_LAST;
        end
      end
      ST_TRL_LAST: begin
        emit = 1'b1;
        emit_word = trl_reg; // [R04]
        emit_last = 1'b1;
        if (advance) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      hdr_ready_reg <= 1'b1;
    end else if (ce) begin
      state_reg <= state_next;
      hdr_ready_reg <= (state_next == ST_IDLE);
    end
  end

  // Header capture; the header inputs need only be valid on the taking edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < HDR_WORDS; i++) begin
        hdr_mem[i] <= '0;
      end
      trl_reg <= '0;
      bulky_reg <= 1'b0;
    end else if (hdr_take) begin
      hdr_mem[0] <= word0;
      hdr_mem[1] <= word1;
      hdr_mem[2] <= word2;
      hdr_mem[3] <= word3;
      trl_reg <= trl_word; // [R17] [R18] [R19]
      bulky_reg <= hdr_bulky;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hidx_reg <= '0;
      quads_left_reg <= '0;
    end else if (hdr_take) begin
      hidx_reg <= HDR_IDX_FIRST;
      quads_left_reg <= quad_count; // [R03]
    end else begin
      if (advance && (state_reg == ST_HDR)) begin
        hidx_reg <= hidx_reg + 2'h1;
      end
      if (pk_take) begin
        quads_left_reg <= quads_left_reg - QCNT_W'(1);
      end
    end
  end

  // The stage holds its word until the FIFO side accepts it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_valid_reg <= 1'b0;
      q_data_reg <= '0;
      q_bulky_reg <= 1'b0;
      q_first_reg <= 1'b0;
      q_last_reg <= 1'b0;
    end else if (advance) begin
      q_valid_reg <= emit;
      q_data_reg <= emit_word;
      q_bulky_reg <= bulky_reg;
      q_first_reg <= emit_first;
      q_last_reg <= emit_last;
    end
  end

  abr_byte_packer u_packer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .byte_last(byte_last),
    .byte_ready(byte_ready),
    .quad_valid(pk_valid),
    .quad_data(pk_data),
    .quad_take(pk_take)
  );

  assign hdr_ready = hdr_ready_reg;
  assign q_valid = q_valid_reg;
  assign q_data = q_data_reg;
  assign q_bulky = q_bulky_reg;
  assign q_first = q_first_reg;
  assign q_last = q_last_reg;

  a_prio_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R09]
    CABLE_MODE && (state_reg != ST_IDLE) |-> hdr_mem[0][PRIO_W-1:0] == PRIO_CABLE)
    else $error("priority not zero in cable mode");

  a_offset_align: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
    hdr_take |=> hdr_mem[2][1:0] == 2'h0 && hdr_mem[2][31:2] == $past(offset_low[31:2]))
    else $error("offset low not quadlet aligned");

  a_lock_rsvd: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
    hdr_take && is_lock_resp |=> hdr_mem[1][11:0] == RCODE_RSVD_ZERO)
    else $error("lock response reserved bits not zero");

  a_bulky_trl: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R04]
    q_valid_reg && q_first_reg && q_bulky_reg |-> q_data_reg == trl_reg)
    else $error("bulky packet does not open with trailer");

  // A header taken while the closing trailer still waits reloads trl_reg, so only the idle stretch is compared.
  a_ctrl_trl: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R04]
    q_valid_reg && q_last_reg && !q_bulky_reg && (state_reg == ST_IDLE) |-> q_data_reg == trl_reg)
    else $error("control packet does not close with trailer");

  a_no_data: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R03]
    in_data |-> abr_has_data(hdr_mem[0][TCODE_LSB +: TCODE_W]))
    else $error("data phase for packet without data");

  a_zero_fill: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R19]
    (state_reg != ST_IDLE) && abr_has_data(hdr_mem[0][TCODE_LSB +: TCODE_W]) |->
      trl_reg[TRL_ZFC_LSB +: ZFC_W] == ZFC_W'(0) - hdr_mem[3][LEN_LSB +: ZFC_W])
    else $error("zero fill count wrong");

  a_hold_stall: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R20]
    q_valid_reg && !q_ready |=> q_valid_reg && $stable(q_data_reg) && $stable(q_last_reg))
    else $error("quadlet changed while stalled");

  a_no_interleave: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R20]
    hdr_take |-> state_reg == ST_IDLE ##1 state_reg != ST_IDLE)
    else $error("header taken inside a packet");

endmodule : abr_rx_formatter

// [hw/abr_trailer_build.sv]
`timescale 1ns/1ps
module abr_trailer_build (
  // Packet fields
  input logic [abr_pkg::LEN_W-1:0] data_length,
  input logic [abr_pkg::TCODE_W-1:0] tcode,
  input logic [abr_pkg::SPD_W-1:0] spd,
  input logic [abr_pkg::ACK_W-1:0] ack_sent,
  // Results
  output logic [abr_pkg::QUAD_W-1:0] trailer,
  output logic [abr_pkg::QCNT_W-1:0] quad_count
);
  import abr_pkg::*;

  wire has_data = abr_has_data(tcode);
  wire [ZFC_W-1:0] zero_fill_count = has_data ? (ZFC_W'(0) - data_length[ZFC_W-1:0]) : '0; // [R19]
  wire [QCNT_W-1:0] quad_round = QCNT_W'(|data_length[ZFC_W-1:0]);

  // Read requests and write responses carry no data quadlets at all.
  assign quad_count = has_data ? ({1'b0, data_length[LEN_W-1:ZFC_W]} + quad_round) : '0; // [R03]
  assign trailer = (QUAD_W'(spd) << TRL_SPD_LSB) | // [R17]
                   (QUAD_W'(zero_fill_count) << TRL_ZFC_LSB) |
                   (QUAD_W'(ack_sent) << TRL_ACK_LSB); // [R18]

endmodule : abr_trailer_build

// [shared/abr_pkg.sv]
package abr_pkg;

  // Word and field widths.
  localparam int QUAD_W = 32;
  localparam int ID_W = 16;
  localparam int BUS_W = 10;
  localparam int NODE_W = 6;
  localparam int TLABEL_W = 6;
  localparam int RETRY_W = 2;
  localparam int TCODE_W = 4;
  localparam int PRIO_W = 4;
  localparam int OFF_HI_W = 16;
  localparam int OFF_LO_W = 32;
  localparam int LEN_W = 16;
  localparam int EXT_W = 16;
  localparam int SPD_W = 2;
  localparam int ACK_W = 4;
  localparam int ZFC_W = 2;
  localparam int QCNT_W = 15;
  localparam int HDR_WORDS = 4;
  localparam int HIDX_W = 2;
  localparam int RCODE_W = 4;

  // Field positions, least significant bit of each field.
  localparam int TCODE_LSB = 4;
  localparam int PRIO_LSB = 0;
  localparam int LEN_LSB = 16;
  localparam int TRL_SPD_LSB = 16;
  localparam int TRL_ZFC_LSB = 12;
  localparam int TRL_ACK_LSB = 0;

  // Header word indices.
  localparam logic [HIDX_W-1:0] HDR_IDX_FIRST = 2'h0;
  localparam logic [HIDX_W-1:0] HDR_IDX_LAST = 2'h3;

  // Quadlet alignment of the destination offset and values of fields forced to zero.
  localparam logic [OFF_LO_W-1:0] QUAD_ALIGN_MASK = 32'hffff_fffc;
  localparam logic [OFF_HI_W-RCODE_W-1:0] RCODE_RSVD_ZERO = 12'h000;
  localparam logic [PRIO_W-1:0] PRIO_CABLE = 4'h0;

  // Retry codes, carried through unchanged.
  localparam logic [RETRY_W-1:0] RETRY_NEW = 2'h0;
  localparam logic [RETRY_W-1:0] RETRY_X = 2'h1;
  localparam logic [RETRY_W-1:0] RETRY_A = 2'h2;
  localparam logic [RETRY_W-1:0] RETRY_B = 2'h3;

  // Received speed codes; the last one is undefined.
  localparam logic [SPD_W-1:0] SPD_100 = 2'h0;
  localparam logic [SPD_W-1:0] SPD_200 = 2'h1;
  localparam logic [SPD_W-1:0] SPD_400 = 2'h2;
  localparam logic [SPD_W-1:0] SPD_UNDEF = 2'h3;

  // Transaction codes.
  localparam logic [TCODE_W-1:0] TC_WRITE_REQ_BLK = 4'h1;
  localparam logic [TCODE_W-1:0] TC_WRITE_RESP = 4'h2;
  localparam logic [TCODE_W-1:0] TC_READ_REQ_BLK = 4'h5;
  localparam logic [TCODE_W-1:0] TC_READ_RESP_BLK = 4'h7;
  localparam logic [TCODE_W-1:0] TC_LOCK_REQ = 4'h9;
  localparam logic [TCODE_W-1:0] TC_LOCK_RESP = 4'hb;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TRL_FIRST,
    ST_HDR,
    ST_DATA,
    ST_TRL_LAST
  } abr_state_t;

  // True for packets that carry a block data field.
  function automatic logic abr_has_data(input logic [TCODE_W-1:0] tcode);
    abr_has_data = (tcode == TC_WRITE_REQ_BLK) || (tcode == TC_READ_RESP_BLK) ||
                   (tcode == TC_LOCK_REQ) || (tcode == TC_LOCK_RESP);
  endfunction : abr_has_data

endpackage : abr_pkg
